// ---- hw/cpu_if_ctl_map.vh ----
`ifndef CPU_IF_CTL_MAP_VH
`define CPU_IF_CTL_MAP_VH
// field positions of the control register
`define CTL_EXT_RANGE_BIT   19
`define CTL_RANGE_SEL_BIT   18
`define CTL_AFF3_BIT        15
`define CTL_LOCAL_ERR_BIT   14
`define CTL_ID_WIDTH_HI     13
`define CTL_ID_WIDTH_LO     11
`define CTL_PRI_HI          10
`define CTL_PRI_LO          8
`define CTL_PRIORITY_MASK_HINT_ENABLE_BIT        6
`define CTL_SPLIT_BIT       1
// fixed field values
`define CTL_EXT_RANGE_VAL   1'h1
`define CTL_RANGE_SEL_VAL   1'h0
`define CTL_AFF3_VAL        1'h1
`define CTL_LOCAL_ERR_VAL   1'h0
`define CTL_ID_WIDTH_VAL    3'h0
`define CTL_PRI_BITS        3'h5
// reset values of the writable bits
`define CTL_PRIORITY_MASK_HINT_ENABLE_RST        1'h0
`define CTL_SPLIT_RST       1'h0
// lowest group 0 binary point is this value less the priority field
`define CTL_BP_MIN_TOP      3'h6
`define CTL_BP_MIN_RST      3'h0
`define CTL_DATA_ZERO       64'h0
`endif

// ---- hw/split_mode_bank.v ----
`timescale 1ns/1ns
`include "cpu_if_ctl_map.vh"
// banked secure / non-secure split mode bits
module split_mode_bank (
  // clock and reset
  input  wire sys_clk,
  input  wire rst_n,
  // write side
  input  wire wr_en,
  input  wire wr_secure,
  input  wire wr_bit,
  // top-level register write path
  input  wire top_wr_en,
  input  wire top_wr_s,
  input  wire top_wr_ns,
  // state
  output reg  secure_split_mode_copy,
  output reg  nonsecure_split_mode_copy
);
  // one flop per security state; top-level writes alias the same flops
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      secure_split_mode_copy    <= `CTL_SPLIT_RST;
      nonsecure_split_mode_copy <= `CTL_SPLIT_RST;
    end else if (top_wr_en) begin
      // top-level register wins when both write together
      secure_split_mode_copy    <= top_wr_s;
      nonsecure_split_mode_copy <= top_wr_ns;
    end else if (wr_en) begin
      if (wr_secure) begin
        secure_split_mode_copy <= wr_bit;
      end else begin
        nonsecure_split_mode_copy <= wr_bit;
      end
    end
  end
endmodule

// ---- hw/cpu_if_control_el1.v ----
`timescale 1ns/1ns
`include "cpu_if_ctl_map.vh"
// What this block does
// - bit 19 reads one, extended range
// - bit 18 reads zero, no range selector
// - bit 15 reads one, writes ignored
// - bit 14 reads zero, writes ignored
// - id width field reads zero encoding
// - priority field reports five bits minus one
// - priority field independent of security inputs
// - priority count sets binary point minimum
// - physical read uses top-level priority field
// - hint enable bit drives hint output
// - hint aliases top level, writable if disable
// - split clear: end-of-irq drops and deactivates
// - split set: only drop, deactivate separate
// - banked secure and non-secure split copies
module cpu_if_control_el1 #(
  parameter [2:0] PRI_BITS_MINUS_ONE = 3'h4
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // system register access
  input  wire        reg_rd_en,
  input  wire        reg_wr_en,
  input  wire        reg_secure,
  input  wire [63:0] reg_wdata,
  output reg  [63:0] reg_rdata,
  output reg         reg_rvalid,
  // top-level control register alias path
  input  wire        top_wr_en,
  input  wire        top_wr_priority_mask_hint_enable,
  input  wire        top_wr_split_s,
  input  wire        top_wr_split_ns,
  input  wire        top_level_present,
  input  wire [2:0]  top_level_pri_field,
  // distributor security disable
  input  wire        distributor_security_disable,
  // end-of-interrupt traffic
  input  wire        eoi_wr,
  input  wire        eoi_secure,
  input  wire        deact_wr,
  // control outputs
  output reg         priority_mask_hint_enable,
  output reg         eoi_priority_drop,
  output reg         eoi_deactivate,
  output reg         deact_unpredictable,
  output reg  [2:0]  group0_bp_min
);
  // all state sits on sys_clk; the only foreign input is the
  // distributor disable, which is synchronised before use
  // synchronised security disable; the distributor runs on its own
  // timing, so its level is trusted only after two flops
  reg        ds_meta_r;     // first stage, only read by second
  reg        ds_r;          // usable level
  // hint bit storage and its next value
  reg        priority_mask_hint_enable_r;        // stored hint enable
  reg        priority_mask_hint_enable_nxt;      // hint value for the next edge
  reg        priority_mask_hint_enable_local_ok; // local write may reach the hint
  // banked split copies
  wire       split_s;       // secure copy from the bank
  wire       split_ns;      // non-secure copy from the bank
  wire       split_cur;     // copy selected by eoi security
  wire       split_acc;     // copy selected by register access
  // read path
  reg  [2:0] pri_field;     // value shown in priority field
  reg [63:0] rd_word;       // assembled read value
  // end-of-interrupt and binary point next values
  reg        drop_nxt;      // priority drop for the next edge
  reg        deact_nxt;     // deactivation for the next edge
  reg        unpred_nxt;    // flagged deactivate for the next edge
  reg  [2:0] bp_min_nxt;    // binary point minimum for the next edge

  // two-flop synchroniser for the distributor control
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // reset reads as security enabled, the locked case
      ds_meta_r <= 1'h0;
      ds_r      <= 1'h0;
    end else begin
      // only ds_r is read by the logic below
      ds_meta_r <= distributor_security_disable;
      ds_r      <= ds_meta_r;
    end
  end

  // banked split bits live in the leaf module; a register write picks
  // its copy by the access security state, a top-level write sets both
  // copies at once so the two views never drift apart
  split_mode_bank u_bank (
    .sys_clk                   (sys_clk),
    .rst_n                     (rst_n),
    .wr_en                     (reg_wr_en),
    .wr_secure                 (reg_secure),
    .wr_bit                    (reg_wdata[`CTL_SPLIT_BIT]),
    .top_wr_en                 (top_wr_en),
    .top_wr_s                  (top_wr_split_s),
    .top_wr_ns                 (top_wr_split_ns),
    .secure_split_mode_copy    (split_s),
    .nonsecure_split_mode_copy (split_ns)
  );

  // end-of-interrupt traffic uses its own security state, register
  // accesses theirs; both may be in flight in the same cycle
  assign split_cur = eoi_secure ? split_s : split_ns;
  assign split_acc = reg_secure ? split_s : split_ns;

  // a local write reaches the hint only when no top level owns it or
  // when the distributor has opened it up; the synchronised level is
  // used, so a change of the disable takes two cycles to show here
  always @* begin
    priority_mask_hint_enable_local_ok = ds_r || !top_level_present;
  end

  // hint next value; the top-level alias write wins so that the two
  // views of the one bit can never disagree
  always @* begin
    if (top_wr_en) begin
      // top-level alias write
      priority_mask_hint_enable_nxt = top_wr_priority_mask_hint_enable;
    end else if (reg_wr_en && priority_mask_hint_enable_local_ok) begin
      // open local write
      priority_mask_hint_enable_nxt = reg_wdata[`CTL_PRIORITY_MASK_HINT_ENABLE_BIT];
    end else begin
      // locked or idle: keep the stored value
      priority_mask_hint_enable_nxt = priority_mask_hint_enable_r;
    end
  end

  // hint storage; the stored bit feeds the read word and the output flop
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      priority_mask_hint_enable_r <= `CTL_PRIORITY_MASK_HINT_ENABLE_RST;
    end else begin
      priority_mask_hint_enable_r <= priority_mask_hint_enable_nxt;
    end
  end

  // priority field: top-level copy when present, security ignored
  // the local count is a parameter so a smaller build can shrink it
  always @* begin
    if (top_level_present) begin
      // physical reads follow the top-level register
      pri_field = top_level_pri_field;
    end else begin
      // no top level: the implemented count, whatever the security
      pri_field = PRI_BITS_MINUS_ONE;
    end
  end

  // read word; every reserved bit is a constant zero
  always @* begin
    rd_word = `CTL_DATA_ZERO;
    rd_word[`CTL_EXT_RANGE_BIT] = `CTL_EXT_RANGE_VAL;
    rd_word[`CTL_RANGE_SEL_BIT] = `CTL_RANGE_SEL_VAL;
    rd_word[`CTL_AFF3_BIT] = `CTL_AFF3_VAL;
    rd_word[`CTL_LOCAL_ERR_BIT] = `CTL_LOCAL_ERR_VAL;
    rd_word[`CTL_ID_WIDTH_HI:`CTL_ID_WIDTH_LO] = `CTL_ID_WIDTH_VAL;
    rd_word[`CTL_PRI_HI:`CTL_PRI_LO] = pri_field;
    // the two live bits; writes never reach the fixed ones above
    rd_word[`CTL_PRIORITY_MASK_HINT_ENABLE_BIT] = priority_mask_hint_enable_r;
    rd_word[`CTL_SPLIT_BIT] = split_acc;
  end

  // read answer one cycle after the request; data held until next read
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= `CTL_DATA_ZERO;
      reg_rvalid <= 1'h0;
    end else begin
      // valid is a one-cycle pulse per read
      reg_rvalid <= reg_rd_en;
      if (reg_rd_en) begin
        // capture; the core may take the word any time before the next read
        reg_rdata <= rd_word;
      end
    end
  end

  // end-of-interrupt decode; with split mode clear an end-of-interrupt
  // write both drops and deactivates, with it set deactivation waits
  // for the separate deactivate write
  // drop and deactivate are one-cycle pulses, one edge after the write
  always @* begin
    // every end-of-interrupt write drops the running priority
    drop_nxt = eoi_wr;
    if (split_cur) begin
      // split: only the deactivate write deactivates
      deact_nxt  = deact_wr;
      unpred_nxt = 1'h0;
    end else begin
      // combined: the end-of-interrupt write deactivates as well
      deact_nxt  = eoi_wr;
      // a deactivate write here has no defined effect; it is only
      // flagged to the core, never acted on, so no state is touched
      unpred_nxt = deact_wr;
    end
  end

  // lowest group 0 binary point follows the implemented priority
  // bits; fewer bits leave fewer subpriority levels to split off
  always @* begin
    bp_min_nxt = `CTL_BP_MIN_TOP - pri_field;
  end

  // registered control outputs, so every pin comes from a flop
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eoi_priority_drop         <= 1'h0;
      eoi_deactivate            <= 1'h0;
      deact_unpredictable       <= 1'h0;
      priority_mask_hint_enable <= `CTL_PRIORITY_MASK_HINT_ENABLE_RST;
      group0_bp_min             <= `CTL_BP_MIN_RST;
    end else begin
      eoi_priority_drop         <= drop_nxt;
      eoi_deactivate            <= deact_nxt;
      deact_unpredictable       <= unpred_nxt;
      // the hint leaves through its own flop to the distributor side
      priority_mask_hint_enable <= priority_mask_hint_enable_r;
      group0_bp_min             <= bp_min_nxt;
    end
  end
endmodule

// ---- verif/cpu_if_ctl_checker.sv ----
`timescale 1ns/1ns
// port-level checks on the control register
module cpu_if_ctl_checker #(parameter [2:0] PRI_BITS_MINUS_ONE = 3'h4) (
  input wire        sys_clk, rst_n, reg_rd_en, reg_wr_en, top_wr_en, eoi_wr,
  input wire        deact_wr, top_level_present, distributor_security_disable,
  input wire        reg_rvalid, priority_mask_hint_enable, eoi_priority_drop,
  input wire        eoi_deactivate,
  input wire [2:0]  top_level_pri_field, group0_bp_min,
  input wire [63:0] reg_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_fixed_ones: assert property (reg_rvalid |-> reg_rdata[19] && reg_rdata[15])
    else $error("fixed ones wrong");
  a_fixed_zeros: assert property (reg_rvalid |-> reg_rdata[18:11] == 8'h10)
    else $error("fixed zeros wrong");
  a_reserved_zero: assert property (reg_rvalid |-> {reg_rdata[63:20], reg_rdata[17:16],
    reg_rdata[7], reg_rdata[5:2]} == 51'h0) else $error("reserved bits set");
  a_pri_field: assert property (reg_rd_en |=> reg_rvalid && reg_rdata[10:8] ==
    ($past(top_level_present) ? $past(top_level_pri_field) : PRI_BITS_MINUS_ONE))
    else $error("priority field wrong");
  // read bit and output flop both lag the stored hint by one edge
  a_hint_read: assert property (reg_rd_en |=>
    reg_rdata[6] == priority_mask_hint_enable) else $error("hint bit wrong");
  // the disable level needs two sync flops before it locks the hint;
  // the output flop shows a refused write one edge later still
  a_hint_locked: assert property ((!distributor_security_disable)[*3] ##0
    (reg_wr_en && !top_wr_en && top_level_present) |-> ##2 $stable(priority_mask_hint_enable))
    else $error("locked hint changed");
  a_eoi_drop: assert property (eoi_wr |=> eoi_priority_drop)
    else $error("no priority drop");
  a_deact_cause: assert property (eoi_deactivate |-> $past(eoi_wr || deact_wr))
    else $error("stray deactivate");
  a_bp_minimum: assert property ($past(rst_n, 2) && !top_level_present &&
    !$past(top_level_present) |-> group0_bp_min == 3'h6 - PRI_BITS_MINUS_ONE)
    else $error("binary point minimum wrong");
  c_read: cover property (reg_rvalid);
  c_lock: cover property (reg_wr_en && top_level_present && !distributor_security_disable);
  c_deact: cover property (deact_wr);
endmodule
bind cpu_if_control_el1 cpu_if_ctl_checker #(.PRI_BITS_MINUS_ONE(PRI_BITS_MINUS_ONE)) chk_u (
  .sys_clk, .rst_n, .reg_rd_en, .reg_wr_en, .top_wr_en, .eoi_wr, .deact_wr,
  .top_level_present, .distributor_security_disable, .reg_rvalid, .priority_mask_hint_enable,
  .eoi_priority_drop, .eoi_deactivate, .top_level_pri_field, .group0_bp_min, .reg_rdata);

// ---- verif/dist_model.sv ----
`timescale 1ns/1ns
// distributor and top-level register side
module dist_model #(parameter [2:0] TOP_PRI = 3'h4) (
  input  wire       sys_clk,
  input  wire       ds_set,
  output reg        distributor_security_disable,
  output wire [2:0] top_level_pri_field
);
  initial distributor_security_disable = 1'h0;
  // disable level moves on a clock edge, like a real register bit
  always @(posedge sys_clk) begin
    distributor_security_disable <= ds_set;
  end
  assign top_level_pri_field = TOP_PRI;
endmodule

// ---- verif/cpu_if_control_el1_tb.sv ----
`timescale 1ns/1ns
module cpu_if_control_el1_tb;
  localparam logic [63:0] BASE = 64'h88400; // fixed fields, priority field 4
  logic sys_clk = 0, rst_n = 0, reg_rd_en = 0, reg_wr_en = 0, reg_secure = 0, ds_set = 0;
  logic top_wr_en = 0, top_wr_priority_mask_hint_enable = 0, top_wr_split_s = 0, top_wr_split_ns = 0;
  logic top_level_present = 0, eoi_wr = 0, eoi_secure = 0, deact_wr = 0;
  logic [63:0] reg_wdata = 0, reg_rdata;
  logic reg_rvalid, priority_mask_hint_enable, eoi_priority_drop, eoi_deactivate;
  logic deact_unpredictable, distributor_security_disable;
  logic [2:0] top_level_pri_field, group0_bp_min;
  int failures = 0, n_compared = 0;
  always #4 sys_clk = ~sys_clk;
  // top-level field differs from the local default so the source shows
  dist_model #(.TOP_PRI(3'h3)) far_u (.sys_clk, .ds_set, .distributor_security_disable,
    .top_level_pri_field);
  cpu_if_control_el1 dut_u (.sys_clk, .rst_n, .reg_rd_en, .reg_wr_en, .reg_secure,
    .reg_wdata, .reg_rdata, .reg_rvalid, .top_wr_en, .top_wr_priority_mask_hint_enable, .top_wr_split_s,
    .top_wr_split_ns, .top_level_present, .top_level_pri_field, .distributor_security_disable,
    .eoi_wr, .eoi_secure, .deact_wr, .priority_mask_hint_enable, .eoi_priority_drop,
    .eoi_deactivate, .deact_unpredictable, .group0_bp_min);
  task chk(input string nm, input logic [63:0] exp, act);
    n_compared++;
    if (act !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, act);
    end
  endtask
  task rd(input logic s, input logic [63:0] exp);
    @(posedge sys_clk) #1 reg_rd_en = 1;
    reg_secure = s;
    @(posedge sys_clk) #1 reg_rd_en = 0;
    chk("rdata", exp, reg_rdata);
    chk("rvalid", 1, reg_rvalid);
  endtask
  task wr(input logic s, input logic [63:0] d);
    @(posedge sys_clk) #1 reg_wr_en = 1;
    reg_secure = s;
    reg_wdata = d;
    @(posedge sys_clk) #1 reg_wr_en = 0;
  endtask
  // e is the expected drop, deactivate and flagged-deactivate triple
  task irq(input logic d, s, input logic [2:0] e);
    @(posedge sys_clk) #1 eoi_wr = !d;
    deact_wr = d;
    eoi_secure = s;
    @(posedge sys_clk) #1 {eoi_wr, deact_wr} = 0;
    chk("eoi_outputs", e, {eoi_priority_drop, eoi_deactivate, deact_unpredictable});
  endtask
  task end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000 failures++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1;
    repeat (3) @(posedge sys_clk);
    #1 chk("bp_min", 2, group0_bp_min);
    rd(0, BASE);
    wr(1, '1);
    rd(1, BASE | 64'h42);
    rd(0, BASE | 64'h40);
    irq(0, 1, 3'h4);
    irq(0, 0, 3'h6);
    irq(1, 1, 3'h2);
    irq(1, 0, 3'h1);
    wr(0, 64'h2);
    rd(0, BASE | 64'h2);
    chk("hint_out", 0, priority_mask_hint_enable);
    top_level_present = 1;
    top_wr_priority_mask_hint_enable = 1;
    top_wr_split_ns = 1;
    @(posedge sys_clk) #1 top_wr_en = 1;
    @(posedge sys_clk) #1 top_wr_en = 0;
    wr(1, 64'h0);
    rd(1, 64'h88340);
    chk("hint_out", 1, priority_mask_hint_enable);
    chk("bp_min", 3, group0_bp_min);
    ds_set = 1;
    repeat (4) @(posedge sys_clk);
    #1 rd(0, 64'h88342);
    wr(0, 64'h0);
    rd(0, 64'h88300);
    end_sim;
  end
endmodule
